// ---- hw/i2cme_pkg.sv ----
// package for the i2c master byte engine: register map, fields, states
// assumes an apb slave with 12-bit byte addresses and 32-bit data
package i2cme_pkg;
  localparam int          ADDR_W       = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_IDX     = 8'he1;
  localparam logic [7:0]  DATA_IDX     = 8'he2;
  localparam logic [7:0]  STAT_IDX     = 8'hc0;
  localparam logic [7:0]  MASK_IDX     = 8'hc1;
  // control field positions
  localparam int          EN_BIT       = 7;
  localparam int          ACKO_BIT     = 6;
  localparam int          FLAG_BIT     = 5;
  localparam int          ACKI_BIT     = 4;
  localparam int          START_BIT    = 3;
  localparam int          STOP_BIT     = 2;
  localparam int          DIV_LSB      = 0;
  // reset values
  localparam logic [7:0]  CTRL_RST     = 8'h04;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [1:0]  MASK_RST     = 2'h0;
  // interrupt status / mask layout
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_DONE_BIT = 0;
  localparam int          IRQ_NACK_BIT = 1;
  // bit slots per byte: eight data bits then the acknowledge slot
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT,
    ST_BIT,
    ST_STOP
  } i2cme_state_t;
endpackage : i2cme_pkg

// ---- hw/i2cme_top.sv ----
// i2c master byte engine: apb registers, scl divider, start/stop, shifting
// assumes open-drain pads outside (oe high pulls the line low) and
// apb inputs synchronous to clk; no clock stretching support
//
// How it works
// R1: start bit issues START, opens transfer
// R2: stop bit drives STOP, resets high
// R3: divider code picks scl fsys/4..fsys/256
// R4: eight-bit shift register, zero at reset
// R5: data write while open sends byte
// R6: data read while open receives next byte
// R7: enable bit gates bus state machine and line drivers
// R8: receive ack driven per ack-out bit
// R9: byte done sets flag, write zero clears
// R10: transmit captures slave ack into status
`timescale 1ns/1ps
module i2cme_top (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [i2cme_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          scl_i,
  output logic                               scl_o,
  output logic                               scl_oe,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe,
  output logic                               irq
);

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [7:0]  idx);
    addr_hit = (a == {2'h0, idx, 2'h0});
  endfunction : addr_hit

  // quarter-period length in clk cycles: 1, 4, 16, 64
  function automatic logic [7:0] qlen(input logic [1:0] d);
    qlen = 8'(8'h01 << {d, 1'b0});
  endfunction : qlen

  // local names for the package states, which are not imported here
  localparam i2cme_pkg::i2cme_state_t ST_IDLE  = i2cme_pkg::ST_IDLE;
  localparam i2cme_pkg::i2cme_state_t ST_START = i2cme_pkg::ST_START;
  localparam i2cme_pkg::i2cme_state_t ST_WAIT  = i2cme_pkg::ST_WAIT;
  localparam i2cme_pkg::i2cme_state_t ST_BIT   = i2cme_pkg::ST_BIT;
  localparam i2cme_pkg::i2cme_state_t ST_STOP  = i2cme_pkg::ST_STOP;

  i2cme_pkg::i2cme_state_t st_r, st_nxt;
  logic [1:0]  phase_r, phase_nxt;
  logic [3:0]  bitc_r, bitc_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        rx_r, rx_nxt;
  logic        scl_oe_r, scl_oe_nxt;
  logic        sda_oe_r, sda_oe_nxt;
  logic        en_r, en_nxt;
  logic        acko_r, acko_nxt;
  logic        flag_r, flag_nxt;
  logic        acki_r, acki_nxt;
  logic        start_r, start_nxt;
  logic        stop_r, stop_nxt;
  logic [1:0]  div_r, div_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        wr, rd, setup, hit_any, tick;
  logic [7:0]  ctrl_view;

  assign wr        = psel & penable & pwrite;
  assign rd        = psel & penable & ~pwrite;
  assign setup     = psel & ~penable;
  assign hit_any   = addr_hit(paddr, i2cme_pkg::CTRL_IDX) |
                     addr_hit(paddr, i2cme_pkg::DATA_IDX) |
                     addr_hit(paddr, i2cme_pkg::STAT_IDX) |
                     addr_hit(paddr, i2cme_pkg::MASK_IDX);
  assign tick      = (cnt_r == 8'h00);
  assign ctrl_view = {en_r, acko_r, flag_r, acki_r,
                      start_r, stop_r, div_r};

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata  = prdata_r;
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = scl_oe_r;
  assign sda_oe  = sda_oe_r;
  assign irq     = |(stat_r & mask_r);

  always_comb begin
    st_nxt     = st_r;
    phase_nxt  = phase_r;
    bitc_nxt   = bitc_r;
    rx_nxt     = rx_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    en_nxt     = en_r;
    acko_nxt   = acko_r;
    flag_nxt   = flag_r;
    acki_nxt   = acki_r;
    start_nxt  = start_r;
    stop_nxt   = stop_r;
    div_nxt    = div_r;
    shift_nxt  = shift_r;
    stat_nxt   = stat_r;
    mask_nxt   = mask_r;
    prdata_nxt = prdata_r;
    // software side first, so hardware sets below win over clears
    if (wr && addr_hit(paddr, i2cme_pkg::CTRL_IDX)) begin
      en_nxt    = pwdata[i2cme_pkg::EN_BIT]; // R7
      acko_nxt  = pwdata[i2cme_pkg::ACKO_BIT];
      start_nxt = pwdata[i2cme_pkg::START_BIT];
      stop_nxt  = pwdata[i2cme_pkg::STOP_BIT];
      div_nxt   = pwdata[i2cme_pkg::DIV_LSB +: 2];
      if (!pwdata[i2cme_pkg::FLAG_BIT]) begin
        flag_nxt = 1'b0; // R9
      end
    end
    if (wr && addr_hit(paddr, i2cme_pkg::MASK_IDX)) begin
      mask_nxt = pwdata[i2cme_pkg::IRQ_W-1:0];
    end
    if (rd && addr_hit(paddr, i2cme_pkg::STAT_IDX)) begin
      stat_nxt = '0;
    end
    if (wr && addr_hit(paddr, i2cme_pkg::DATA_IDX) && st_r != ST_BIT) begin
      shift_nxt = pwdata[7:0]; // R4
    end
    if (setup && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      if (addr_hit(paddr, i2cme_pkg::CTRL_IDX)) prdata_nxt[7:0] = ctrl_view;
      if (addr_hit(paddr, i2cme_pkg::DATA_IDX)) prdata_nxt[7:0] = shift_r;
      if (addr_hit(paddr, i2cme_pkg::STAT_IDX)) prdata_nxt[1:0] = stat_r;
      if (addr_hit(paddr, i2cme_pkg::MASK_IDX)) prdata_nxt[1:0] = mask_r;
    end
    // quarter-period timer only runs while the bus is being clocked
    if (st_r == ST_IDLE || st_r == ST_WAIT || tick) begin
      cnt_nxt = qlen(div_r) - 8'h01; // R3
    end else begin
      cnt_nxt = cnt_r - 8'h01;
    end
    case (st_r)
      ST_IDLE: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (start_r) begin
          st_nxt    = ST_START; // R1
          phase_nxt = 2'h2;
        end
      end
      ST_START: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: sda_oe_nxt = 1'b0;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b1; // R1
            default: begin
              scl_oe_nxt = 1'b1;
              st_nxt     = ST_WAIT;
              start_nxt  = 1'b0;
              stop_nxt   = 1'b0;
            end
          endcase
        end
      end
      ST_WAIT: begin
        phase_nxt = 2'h0;
        bitc_nxt  = 4'h0;
        if (wr && addr_hit(paddr, i2cme_pkg::DATA_IDX)) begin
          st_nxt = ST_BIT; // R5
          rx_nxt = 1'b0;
        end else if (rd && addr_hit(paddr, i2cme_pkg::DATA_IDX)) begin
          st_nxt = ST_BIT; // R6
          rx_nxt = 1'b1;
        end else if (start_r) begin
          st_nxt = ST_START;
        end else if (stop_r) begin
          st_nxt = ST_STOP; // R2
        end
      end
      ST_BIT: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: begin
              if (bitc_r == i2cme_pkg::ACK_SLOT) begin
                sda_oe_nxt = rx_r & ~acko_r; // R8
              end else begin
                sda_oe_nxt = ~rx_r & ~shift_r[7];
              end
            end
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: begin
              if (bitc_r != i2cme_pkg::ACK_SLOT) begin
                shift_nxt = {shift_r[6:0], sda_i}; // R4
              end else if (!rx_r) begin
                acki_nxt = sda_i; // R10
                if (sda_i) stat_nxt[i2cme_pkg::IRQ_NACK_BIT] = 1'b1;
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              bitc_nxt   = bitc_r + 4'h1;
              if (bitc_r == i2cme_pkg::ACK_SLOT) begin
                st_nxt   = ST_WAIT;
                flag_nxt = 1'b1; // R9
                stat_nxt[i2cme_pkg::IRQ_DONE_BIT] = 1'b1;
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          phase_nxt = phase_r + 2'h1;
          case (phase_r)
            2'h0: sda_oe_nxt = 1'b1;
            2'h1: scl_oe_nxt = 1'b0;
            default: begin
              sda_oe_nxt = 1'b0; // R2
              st_nxt     = ST_IDLE;
            end
          endcase
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    // disabled: release both lines and drop any open transfer
    if (!en_r) begin
      st_nxt     = ST_IDLE; // R7
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      phase_r  <= 2'h0;
      bitc_r   <= 4'h0;
      cnt_r    <= 8'h00;
      rx_r     <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      en_r     <= i2cme_pkg::CTRL_RST[i2cme_pkg::EN_BIT];
      acko_r   <= i2cme_pkg::CTRL_RST[i2cme_pkg::ACKO_BIT];
      flag_r   <= i2cme_pkg::CTRL_RST[i2cme_pkg::FLAG_BIT];
      acki_r   <= i2cme_pkg::CTRL_RST[i2cme_pkg::ACKI_BIT];
      start_r  <= i2cme_pkg::CTRL_RST[i2cme_pkg::START_BIT];
      stop_r   <= i2cme_pkg::CTRL_RST[i2cme_pkg::STOP_BIT];
      div_r    <= i2cme_pkg::CTRL_RST[i2cme_pkg::DIV_LSB +: 2];
      shift_r  <= i2cme_pkg::DATA_RST;
      stat_r   <= '0;
      mask_r   <= i2cme_pkg::MASK_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      st_r     <= st_nxt;
      phase_r  <= phase_nxt;
      bitc_r   <= bitc_nxt;
      cnt_r    <= cnt_nxt;
      rx_r     <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      en_r     <= en_nxt;
      acko_r   <= acko_nxt;
      flag_r   <= flag_nxt;
      acki_r   <= acki_nxt;
      start_r  <= start_nxt;
      stop_r   <= stop_nxt;
      div_r    <= div_nxt;
      shift_r  <= shift_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic data_wr, data_rd, q_end;
  assign data_wr = wr && addr_hit(paddr, i2cme_pkg::DATA_IDX);
  assign data_rd = rd && addr_hit(paddr, i2cme_pkg::DATA_IDX);
  assign q_end   = tick && en_r && !wr;

  start_done_a: assert property ( // R1
    (st_r == ST_START && phase_r == 2'h3 && q_end)
      |=> (st_r == ST_WAIT && scl_oe_r && sda_oe_r && !start_r))
    else $error("start did not reach wait state");
  stop_done_a: assert property ( // R2
    (st_r == ST_STOP && phase_r == 2'h2 && q_end)
      |=> (st_r == ST_IDLE && !sda_oe_r && !scl_oe_r))
    else $error("stop did not release the bus");
  div_len_a: assert property ( // R3
    (st_r == ST_BIT && tick && !wr)
      |=> (cnt_r == qlen(div_r) - 8'h01))
    else $error("quarter period length wrong");
  shift_in_a: assert property ( // R4
    (st_r == ST_BIT && phase_r == 2'h2 && bitc_r < 4'h8 && q_end)
      |=> (shift_r[0] == $past(sda_i)))
    else $error("received bit not shifted in");
  tx_load_a: assert property ( // R5
    (data_wr && st_r == ST_WAIT && en_r)
      |=> (st_r == ST_BIT && !rx_r && shift_r == $past(pwdata[7:0])))
    else $error("data write did not start transmit");
  rx_go_a: assert property ( // R6
    (data_rd && st_r == ST_WAIT && en_r) |=> (st_r == ST_BIT && rx_r))
    else $error("data read did not start receive");
  en_off_a: assert property ( // R7
    !en_r |=> (st_r == ST_IDLE && !scl_oe_r && !sda_oe_r))
    else $error("disabled engine still drives bus");
  ack_out_a: assert property ( // R8
    (st_r == ST_BIT && bitc_r == 4'h8 && phase_r == 2'h0 && q_end && rx_r)
      |=> (sda_oe_r == !$past(acko_r)))
    else $error("receive acknowledge level wrong");
  flag_set_a: assert property ( // R9
    (st_r == ST_BIT && bitc_r == 4'h8 && phase_r == 2'h3 && q_end)
      |=> (flag_r && stat_r[i2cme_pkg::IRQ_DONE_BIT] ##1 irq || !mask_r[0]))
    else $error("byte done flag not set");
  ack_in_a: assert property ( // R10
    (st_r == ST_BIT && bitc_r == 4'h8 && phase_r == 2'h2 && q_end && !rx_r)
      |=> (acki_r == $past(sda_i)))
    else $error("slave acknowledge not captured");

  tx_byte_c: cover property (st_r == ST_BIT && !rx_r ##1 st_r == ST_WAIT);
  rx_byte_c: cover property (st_r == ST_BIT && rx_r ##1 st_r == ST_WAIT);
  stop_c:    cover property (st_r == ST_STOP ##1 st_r == ST_IDLE);

endmodule : i2cme_top

// ---- dv/i2cme_slave.sv ----
// behavioural slave for the byte engine bench: takes or sends bytes, acks
// assumes wired-and scl/sda with pull-ups resolved by the bench
`timescale 1ns/1ps
module i2cme_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       rd,
  input  wire logic       nack,
  input  wire logic [7:0] tx_byte,
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic            m_ack
);
  int   idx = 9;
  logic act = 1'b0;
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    idx = 9;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) begin
    if (idx < 8) rx_byte = {rx_byte[6:0], sda};
    if (idx == 8) m_ack = sda;
  end
  // bits change only while scl is low; idle slot 9 keeps the line free
  always @(negedge scl) idx = (idx >= 8) ? 0 : idx + 1;
  assign sda_pull = act && (idx < 8 ? rd && !tx_byte[7 - idx] :
                            idx == 8 && !rd && !nack);
endmodule : i2cme_slave

// ---- dv/i2cme_top_tb.sv ----
// bench for the byte engine: apb tasks, slave model, directed checks
// assumes open-drain lines with pull-ups, resolved here
`timescale 1ns/1ps
module i2cme_top_tb;
  logic                         clk, rst_n, psel, penable, pwrite, err;
  logic [i2cme_pkg::ADDR_W-1:0] paddr;
  logic [31:0]                  pwdata, prdata, rv;
  logic                         pready, pslverr, scl_oe, sda_oe, irq;
  logic                         s_pull, m_ack, rd, nack;
  logic [7:0]                   tx_byte, rx_byte;
  wire                          scl = !scl_oe;
  wire                          sda = !(sda_oe || s_pull);
  int                           n_fail, checks_done, per;
  i2cme_top i2cme_top_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .irq(irq));
  i2cme_slave i2cme_slave_i (.scl(scl), .sda(sda), .rd(rd), .nack(nack),
    .tx_byte(tx_byte), .sda_pull(s_pull), .rx_byte(rx_byte), .m_ack(m_ack));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until pready is seen high at an edge
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_fail++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic ctl(input logic [7:0] v);
    apb(1'b1, i2cme_pkg::CTRL_IDX, v);
  endtask : ctl
  task automatic wait_ctl(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, i2cme_pkg::CTRL_IDX, 8'h00);
      n++;
      if (n > 2000) begin
        n_fail++;
        tally_and_finish();
      end
    end while (rv[b] !== v);
  endtask : wait_ctl
  task automatic scl_period(output int p);
    int   n, t0, r;
    logic pv;
    n = 0;
    r = 0;
    p = 0;
    t0 = 0;
    pv = scl;
    while (r < 2 && n < 3000) begin
      @(posedge clk);
      n++;
      if (scl && !pv) begin
        if (r == 1) p = n - t0;
        t0 = n;
        r++;
      end
      pv = scl;
    end
  endtask : scl_period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, rd, nack} = 6'h00;
    paddr = '0;
    pwdata = '0;
    tx_byte = 8'h00;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, i2cme_pkg::CTRL_IDX, 8'h00);
    chk(rv, 32'h0000_0004);
    ctl(8'h00);
    apb(1'b0, i2cme_pkg::DATA_IDX, 8'h00);
    chk(rv, 32'h0000_0000);
    apb(1'b1, 8'h10, 8'hff);
    chk({31'h0, err}, 32'h0000_0001);
    // start with the enable clear must leave both lines alone
    ctl(8'h08);
    repeat (8) @(posedge clk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
    apb(1'b1, i2cme_pkg::MASK_IDX, 8'h03);
    $display("test reset and enable done");
    for (int d = 0; d < 4; d++) begin
      ctl(8'h88 | 8'(d));
      wait_ctl(i2cme_pkg::START_BIT, 1'b0);
      fork
        scl_period(per);
        apb(1'b1, i2cme_pkg::DATA_IDX, 8'hA5 ^ 8'(d));
      join
      wait_ctl(i2cme_pkg::FLAG_BIT, 1'b1);
      chk(per, 32'(4 << (2 * d)));
      chk({24'h0, rx_byte}, {24'h0, 8'hA5 ^ 8'(d)});
      chk({31'h0, rv[i2cme_pkg::ACKI_BIT]}, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b0, i2cme_pkg::STAT_IDX, 8'h00);
      chk(rv, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      ctl(8'h84 | 8'(d));
      repeat ((3 << (2 * d)) + 8) @(posedge clk);
      chk({30'h0, scl, sda}, 32'h0000_0003);
      apb(1'b0, i2cme_pkg::CTRL_IDX, 8'h00);
      chk({31'h0, rv[i2cme_pkg::FLAG_BIT]}, 32'h0000_0000);
    end
    $display("test transmit at each divider done");
    ctl(8'h88);
    wait_ctl(i2cme_pkg::START_BIT, 1'b0);
    rd <= 1'b1;
    tx_byte <= 8'h3C;
    apb(1'b0, i2cme_pkg::DATA_IDX, 8'h00);
    wait_ctl(i2cme_pkg::FLAG_BIT, 1'b1);
    chk({31'h0, m_ack}, 32'h0000_0000);
    ctl(8'hC0);
    tx_byte <= 8'hC3;
    apb(1'b0, i2cme_pkg::DATA_IDX, 8'h00);
    chk(rv, 32'h0000_003C);
    wait_ctl(i2cme_pkg::FLAG_BIT, 1'b1);
    chk({31'h0, m_ack}, 32'h0000_0001);
    rd <= 1'b0;
    ctl(8'h84);
    repeat (12) @(posedge clk);
    apb(1'b0, i2cme_pkg::DATA_IDX, 8'h00);
    chk(rv, 32'h0000_00C3);
    $display("test receive done");
    apb(1'b1, i2cme_pkg::MASK_IDX, 8'h00);
    apb(1'b0, i2cme_pkg::STAT_IDX, 8'h00);
    nack <= 1'b1;
    ctl(8'h88);
    wait_ctl(i2cme_pkg::START_BIT, 1'b0);
    apb(1'b1, i2cme_pkg::DATA_IDX, 8'h5A);
    wait_ctl(i2cme_pkg::FLAG_BIT, 1'b1);
    chk({31'h0, rv[i2cme_pkg::ACKI_BIT]}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, i2cme_pkg::MASK_IDX, 8'h03);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b0, i2cme_pkg::STAT_IDX, 8'h00);
    chk(rv, 32'h0000_0003);
    nack <= 1'b0;
    ctl(8'h84);
    $display("test not-acknowledge done");
    tally_and_finish();
  end
endmodule : i2cme_top_tb
